// file: logic/query_table_defs.svh
// constants for the erase region query table: offsets, field positions, default contents
// assumes inclusion by the package and design files of this block only
`ifndef QUERY_TABLE_DEFS_SVH
`define QUERY_TABLE_DEFS_SVH

// query byte addresses of the covered entries
`define QA_REGION_COUNT 12'h135
`define QA_T1_GEOM 12'h136
`define QA_T1_ENDUR 12'h13a
`define QA_T1_CELL 12'h13c
`define QA_T1_CAPS 12'h13d
`define QA_T1_PROG 12'h13e
`define QA_T2_GEOM 12'h144
`define QA_T2_ENDUR 12'h148
`define QA_T2_CELL 12'h14a
`define QA_T2_CAPS 12'h14b
`define QA_FIRST 12'h135
`define QA_LAST 12'h14b
`define QA_SPAN 23

// apb byte address: one query byte per aligned word
`define APB_TABLE_BASE 14'h04d4
`define APB_CTRL 14'h0000
`define APB_STATUS 14'h0004

// field layouts
`define CELL_BPC_MASK 8'h0f
`define CELL_ECC_BIT 4
`define CELL_VALID_MASK 8'h1f
`define CAPS_VALID_MASK 8'h07
`define PROG_LEGACY_LO 15
`define PROG_LEGACY_HI 47
`define BLOCK_SIZE_UNIT 256
`define ENDURANCE_UNIT 1000

// default contents (bottom parameter arrangement)
`define DEF_REGION_COUNT 8'h02
`define DEF_T1_GEOM 32'h0080_0003
`define DEF_T1_ENDUR 16'h0064
`define DEF_T1_CELL 8'h02
`define DEF_T1_CAPS 8'h03
`define DEF_T1_PROG 48'h8000_0000_8000
`define DEF_T2_GEOM 32'h0200_01fe
`define DEF_T2_ENDUR 16'h0064
`define DEF_T2_CELL 8'h02
`define DEF_T2_CAPS 8'h03

// query enable value after reset: table readable from the start
`define RESET_CTRL 1'b1
`endif

// file: logic/query_table_pkg.sv
// types shared by the query table design files
// assumes query_table_defs.svh is on the include path
package query_table_pkg;
   `include "query_table_defs.svh"

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS
   } apb_state_t;

   typedef struct packed {
      apb_state_t state;
      logic [31:0] prdata;
      logic pslverr;
      logic query_en;
      logic [15:0] read_count;
      logic write_seen;
   } slave_state_t;
endpackage

// file: logic/query_byte_rom.sv
// constant byte table of the erase region entries, one byte per query address
// assumes a combinational lookup is acceptable; contents never change after build
`timescale 1ns/1ps
`include "query_table_defs.svh"
module query_byte_rom
   import query_table_pkg::*;
#(
   parameter logic [31:0] T1_GEOM = `DEF_T1_GEOM,
   parameter logic [15:0] T1_ENDUR = `DEF_T1_ENDUR,
   parameter logic [7:0] T1_CELL = `DEF_T1_CELL,
   parameter logic [7:0] T1_CAPS = `DEF_T1_CAPS,
   parameter logic [47:0] T1_PROG = `DEF_T1_PROG,
   parameter logic [31:0] T2_GEOM = `DEF_T2_GEOM,
   parameter logic [15:0] T2_ENDUR = `DEF_T2_ENDUR,
   parameter logic [7:0] T2_CELL = `DEF_T2_CELL,
   parameter logic [7:0] T2_CAPS = `DEF_T2_CAPS
) (
   // lookup
   input wire logic [11:0] qaddr,
   output logic [7:0] qdata,
   output logic hit
);
   // whole image, lowest address in the low byte (see RULE12)
   localparam int NB = `QA_SPAN;
   localparam logic [NB*8-1:0] IMAGE = {
      T2_CAPS & `CAPS_VALID_MASK, // see RULE6
      T2_CELL & `CELL_VALID_MASK, // see RULE5
      T2_ENDUR, // see RULE4
      T2_GEOM, // see RULE9 see RULE10
      T1_PROG & 48'h80ff_00ff_80ff, // see RULE7 see RULE8
      T1_CAPS & `CAPS_VALID_MASK,
      T1_CELL & `CELL_VALID_MASK,
      T1_ENDUR,
      T1_GEOM, // see RULE1 see RULE2 see RULE3
      `DEF_REGION_COUNT // see RULE11
   };

   logic [11:0] idx;

   // index into the image; out of range reads as zero
   always_comb begin
      idx = qaddr - `QA_FIRST;
      hit = (qaddr >= `QA_FIRST) && (qaddr <= `QA_LAST);
      qdata = hit ? IMAGE[idx[4:0]*8 +: 8] : 8'h00;
   end
endmodule

// file: logic/query_apb_port.sv
// apb address decoder mapping byte addresses to query addresses
// assumes word aligned apb addresses
`timescale 1ns/1ps
`include "query_table_defs.svh"
module query_apb_port
   import query_table_pkg::*;
(
   // bus side
   input wire logic [13:0] paddr,
   // decode
   output logic [11:0] qaddr,
   output logic is_table,
   output logic is_ctrl,
   output logic is_status
);
   // table words start at four times the first query address
   always_comb begin
      qaddr = paddr[13:2];
      is_table = (paddr >= `APB_TABLE_BASE) && (paddr[1:0] == 2'b00);
      is_ctrl = (paddr == `APB_CTRL);
      is_status = (paddr == `APB_STATUS);
   end
endmodule

// file: logic/flash_query_erase_region_table.sv
// apb slave exposing the read-only erase region query table, one byte per word
// assumes a single apb master on pclk; all inputs synchronous to pclk
//
// Notes on behaviour
// RULE1: type 1 descriptor occupies query bytes 136 to 139.
// RULE2: low 16 bits of type 1 descriptor are block count minus one.
// RULE3: high 16 bits of type 1 descriptor are block size over 256.
// RULE4: two-byte endurance fields at 13A and 148, in thousands of cycles.
// RULE5: cell bytes 13C and 14A: bits per cell, ECC flag, reserved bits.
// RULE6: capability bytes 13D and 14B: page read, sync read, sync write flags.
// RULE7: programming region low byte is log2 size; bit 15 marks legacy.
// RULE8: valid and invalid sizes in bits 16-23, 32-39; bit 47 legacy.
// RULE9: type 2 descriptor at 144 to 147; low half is count minus one.
// RULE10: type 2 high half is block size over 256, bottom parameter only.
// RULE11: byte 135 gives number of erase block regions; zero is bulk.
// RULE12: multi-byte fields little endian; reserved bits read zero.
// RULE13: table is constant; writes never change returned contents.
`timescale 1ns/1ps
`include "query_table_defs.svh"
module flash_query_erase_region_table
   import query_table_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr
);
   slave_state_t s_r, s_nxt;
   logic [11:0] qaddr;
   logic is_table, is_ctrl, is_status;
   logic [7:0] qdata;
   logic hit;

   query_apb_port u_dec (
      .paddr(paddr),
      .qaddr(qaddr),
      .is_table(is_table),
      .is_ctrl(is_ctrl),
      .is_status(is_status)
   );

   query_byte_rom u_rom (
      .qaddr(qaddr),
      .qdata(qdata),
      .hit(hit)
   );

   // no wait state: answer in the first access cycle, with read data coming from a flop
   assign pready = (s_r.state == ST_ACCESS);
   assign prdata = s_r.prdata;
   assign pslverr = s_r.pslverr;

   // next state: capture answer at setup, present it during access
   always_comb begin
      s_nxt = s_r;
      unique case (s_r.state)
         ST_IDLE: begin
            if (psel && !penable) begin
               s_nxt.state = ST_ACCESS;
               s_nxt.prdata = 32'h0000_0000;
               s_nxt.pslverr = 1'b0;
               if (is_ctrl) begin
                  if (pwrite && pstrb[0]) begin
                     s_nxt.query_en = pwdata[0];
                  end
                  s_nxt.prdata = {31'h0, s_r.query_en};
               end else if (is_status) begin
                  s_nxt.prdata = {s_r.read_count, 15'h0, s_r.write_seen};
               end else if (is_table && hit && s_r.query_en) begin
                  if (pwrite) begin
                     // writes are refused; contents stay fixed
                     s_nxt.pslverr = 1'b1; // see RULE13
                     s_nxt.write_seen = 1'b1;
                  end else begin
                     s_nxt.prdata = {24'h0, qdata}; // see RULE12
                     s_nxt.read_count = s_r.read_count + 16'h0001;
                  end
               end else begin
                  s_nxt.pslverr = 1'b1;
               end
            end
         end
         ST_ACCESS: begin
            s_nxt.state = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{state: ST_IDLE, prdata: 32'h0, pslverr: 1'b0, query_en: `RESET_CTRL,
                  read_count: 16'h0, write_seen: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // check helpers: request taken at this edge, and a read taken with query mode on
   logic take, take_rd;
   assign take = psel && !penable && (s_r.state == ST_IDLE);
   assign take_rd = take && !pwrite && s_r.query_en;

   // reference bytes kept apart from the packed rom image, so a slip in packing or indexing shows up
   function automatic logic [7:0] ref_byte(input logic [11:0] q);
      logic [7:0] b;
      b = 8'h00;
      case (q)
         12'h135: b = 8'h02;
         12'h136: b = 8'h03;
         12'h137: b = 8'h00;
         12'h138: b = 8'h80;
         12'h139: b = 8'h00;
         12'h13a: b = 8'h64;
         12'h13b: b = 8'h00;
         12'h13c: b = 8'h02;
         12'h13d: b = 8'h03;
         12'h13e: b = 8'h00;
         12'h13f: b = 8'h80;
         12'h140: b = 8'h00;
         12'h141: b = 8'h00;
         12'h142: b = 8'h00;
         12'h143: b = 8'h80;
         12'h144: b = 8'hfe;
         12'h145: b = 8'h01;
         12'h146: b = 8'h00;
         12'h147: b = 8'h02;
         12'h148: b = 8'h64;
         12'h149: b = 8'h00;
         12'h14a: b = 8'h02;
         12'h14b: b = 8'h03;
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // handshake: answer one cycle after setup, for one cycle, then held until the next setup
   a_ready_after_setup: assert property (
      @(posedge pclk) disable iff (!presetn)
      take
      |=> pready)
      else $error("pready not raised after setup");

   a_ready_one_cycle: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready
      |=> !pready)
      else $error("pready held too long");

   a_data_stands: assert property (
      @(posedge pclk) disable iff (!presetn)
      !take
      |=> $stable(prdata) && $stable(pslverr))
      else $error("answer changed without a new setup");

   // refusals and side effects; writes must never reach the table contents
   a_write_refused: assert property ( // see RULE13
      @(posedge pclk) disable iff (!presetn)
      take && pwrite && is_table
      |=> pslverr)
      else $error("table write not refused");

   a_write_no_count: assert property ( // see RULE13
      @(posedge pclk) disable iff (!presetn)
      take && pwrite
      |=> $stable(s_r.read_count))
      else $error("write counted as table read");

   a_write_flagged: assert property ( // see RULE13
      @(posedge pclk) disable iff (!presetn)
      take && pwrite && is_table && hit && s_r.query_en
      |=> s_r.write_seen)
      else $error("table write attempt not flagged");

   a_unmapped_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      take && !is_ctrl && !is_status && !(is_table && hit)
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   a_disabled_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      take && is_table && hit && !s_r.query_en
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("table access with query off not refused");

   a_read_count: assert property (
      @(posedge pclk) disable iff (!presetn)
      take_rd && is_table && hit
      |=> s_r.read_count == $past(s_r.read_count) + 16'h0001)
      else $error("table read not counted");

   a_ctrl_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      take && is_ctrl
      |=> !pslverr && prdata == {31'h0, $past(s_r.query_en)})
      else $error("control readback wrong");

   a_ctrl_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      take && is_ctrl && pwrite && pstrb[0]
      |=> s_r.query_en == $past(pwdata[0]))
      else $error("query enable not written");

   a_status_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      take && is_status
      |=> !pslverr && prdata == {$past(s_r.read_count), 15'h0, $past(s_r.write_seen)})
      else $error("status readback wrong");

   a_status_sticky: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_r.write_seen
      |=> s_r.write_seen)
      else $error("write flag cleared");

   // table contents, byte by byte, as the host sees them
   a_reserved_zero: assert property ( // see RULE12
      @(posedge pclk) disable iff (!presetn)
      pready && !pslverr && $past(is_table)
      |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");

   a_table_byte: assert property ( // see RULE1 see RULE9 see RULE12
      @(posedge pclk) disable iff (!presetn)
      take_rd && is_table && hit
      |=> prdata == {24'h0, ref_byte($past(qaddr))})
      else $error("table byte wrong");

   a_count_byte: assert property ( // see RULE11
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04d4
      |=> prdata == 32'h0000_0002)
      else $error("region count wrong");

   a_t1_low: assert property ( // see RULE1 see RULE2
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04d8
      |=> prdata == 32'h0000_0003)
      else $error("type 1 count byte wrong");

   a_t1_size: assert property ( // see RULE3
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04e0
      |=> prdata == 32'h0000_0080)
      else $error("type 1 size byte wrong");

   a_t1_size_hi: assert property ( // see RULE3
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04e4
      |=> prdata == 32'h0000_0000)
      else $error("type 1 size high byte wrong");

   a_t1_endur: assert property ( // see RULE4
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04e8
      |=> prdata == 32'h0000_0064)
      else $error("type 1 endurance wrong");

   a_t1_endur_hi: assert property ( // see RULE4
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04ec
      |=> prdata == 32'h0000_0000)
      else $error("type 1 endurance high byte wrong");

   a_t1_cell: assert property ( // see RULE5
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04f0
      |=> prdata == 32'h0000_0002)
      else $error("type 1 cell byte wrong");

   a_t1_caps: assert property ( // see RULE6
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04f4
      |=> prdata == 32'h0000_0003)
      else $error("type 1 caps byte wrong");

   a_prog_legacy: assert property ( // see RULE7
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h04fc
      |=> prdata == 32'h0000_0080)
      else $error("legacy flag byte wrong");

   a_prog_valid: assert property ( // see RULE8
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h0500
      |=> prdata == 32'h0000_0000)
      else $error("valid size byte wrong");

   a_prog_hi_legacy: assert property ( // see RULE8
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h050c
      |=> prdata == 32'h0000_0080)
      else $error("bit 47 byte wrong");

   a_t2_count: assert property ( // see RULE9
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h0510
      |=> prdata == 32'h0000_00fe)
      else $error("type 2 count wrong");

   a_t2_count_hi: assert property ( // see RULE9
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h0514
      |=> prdata == 32'h0000_0001)
      else $error("type 2 count high byte wrong");

   a_t2_size_lo: assert property ( // see RULE10
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h0518
      |=> prdata == 32'h0000_0000)
      else $error("type 2 size low byte wrong");

   a_t2_size: assert property ( // see RULE10
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h051c
      |=> prdata == 32'h0000_0002)
      else $error("type 2 size wrong");

   a_endur_byte: assert property ( // see RULE4
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h0520
      |=> prdata == 32'h0000_0064)
      else $error("type 2 endurance wrong");

   a_cell_reserved: assert property ( // see RULE5
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h0528
      |=> prdata[7:5] == 3'h0)
      else $error("cell reserved bits set");

   a_caps_reserved: assert property ( // see RULE6
      @(posedge pclk) disable iff (!presetn)
      take_rd && paddr == 14'h052c
      |=> prdata[7:3] == 5'h0)
      else $error("caps reserved bits set");
endmodule

// file: testbench/query_host_model.sv
// apb master standing in for the host that reads the query table
// assumes calls are made just after a rising pclk edge; one idle cycle between transfers
`timescale 1ns/1ps
module query_host_model (
   // clock
   input wire logic pclk,
   // apb master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [13:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   // bus idle at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 14'h0000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end

   // one full transfer; holds the request until pready is seen at an edge
   task automatic xfer(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      // leading edge keeps release and next setup out of one time step
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no cycle count assumed; only the bench watchdog ends a stuck wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// file: testbench/test_flash_query_erase_region_table.sv
// self-checking bench for the erase region query table over apb
// assumes the host model drives the bus; table holds the bottom parameter contents
`timescale 1ns/1ps
module test_flash_query_erase_region_table;
   import query_table_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [7:0] got [0:22];
   int n_fail = 0;
   int n_tests = 0;
   // expected bytes for query addresses 135 to 14b
   logic [7:0] tbl [0:22] = '{8'h02, 8'h03, 8'h00, 8'h80, 8'h00, 8'h64, 8'h00, 8'h02, 8'h03, 8'h00, 8'h80,
      8'h00, 8'h00, 8'h00, 8'h80, 8'hfe, 8'h01, 8'h00, 8'h02, 8'h64, 8'h00, 8'h02, 8'h03};

   flash_query_erase_region_table u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr));
   query_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

   // 250 mhz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // whole table in byte order, then decoded fields
   task automatic t_table();
      for (int i = 0; i < 23; i++) begin
         u_host.xfer(1'b0, 14'h04d4 + 14'(4 * i), 32'h0, rd, err);
         check(rd, {24'h0, tbl[i]});
         check({31'h0, err}, 32'h0);
         got[i] = rd[7:0];
      end
      check({24'h0, got[0]}, 32'h2);
      check({got[2], got[1]} + 32'h1, 32'd4);
      check({got[4], got[3]} * 256, 32'd32768);
      check({got[6], got[5]} * 1000, 32'd100000);
      check({got[20], got[19]} * 1000, 32'd100000);
      check({16'h0, got[7] & 8'he0, got[21] & 8'he0}, 32'h0);
      check({16'h0, got[8] & 8'hf8, got[22] & 8'hf8}, 32'h0);
      check({30'h0, got[10][7], got[14][7]}, 32'h3);
      check({got[16], got[15]} + 32'h1, 32'd511);
      check({got[18], got[17]} * 256, 32'd131072);
      $display("table read done");
   endtask

   // table write refused, contents kept, attempt flagged
   task automatic t_write();
      u_host.xfer(1'b1, 14'h04d8, 32'h0000_00ff, rd, err);
      check({31'h0, err}, 32'h1);
      u_host.xfer(1'b0, 14'h04d8, 32'h0, rd, err);
      check(rd, 32'h0000_0003);
      u_host.xfer(1'b0, 14'h0004, 32'h0, rd, err);
      // 23 table reads plus one here; write attempt flagged
      check(rd, 32'h0018_0001);
      $display("write refusal done");
   endtask

   // unmapped reads and query enable off
   task automatic t_decode();
      u_host.xfer(1'b0, 14'h0008, 32'h0, rd, err);
      check({err, rd[30:0]}, 32'h8000_0000);
      u_host.xfer(1'b0, 14'h0530, 32'h0, rd, err);
      check({err, rd[30:0]}, 32'h8000_0000);
      u_host.xfer(1'b0, 14'h0000, 32'h0, rd, err);
      check(rd, 32'h1);
      u_host.xfer(1'b1, 14'h0000, 32'h0, rd, err);
      check({err, rd[30:0]}, 32'h1);
      u_host.xfer(1'b0, 14'h052c, 32'h0, rd, err);
      check({err, rd[30:0]}, 32'h8000_0000);
      u_host.xfer(1'b1, 14'h0000, 32'h1, rd, err);
      u_host.xfer(1'b0, 14'h052c, 32'h0, rd, err);
      check({err, rd[30:0]}, 32'h3);
      $display("decode done");
   endtask

   // mid-run reset: outputs cleared, query enable and status back to reset values
   task automatic t_reset();
      u_host.xfer(1'b1, 14'h0000, 32'h0, rd, err);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check({30'h0, pslverr, pready}, 32'h0);
      check(prdata, 32'h0);
      presetn <= 1'b1;
      u_host.xfer(1'b0, 14'h0000, 32'h0, rd, err);
      check(rd, 32'h1);
      u_host.xfer(1'b0, 14'h0004, 32'h0, rd, err);
      check(rd, 32'h0);
      $display("mid-run reset done");
   endtask

   // watchdog well past the expected run of about 120 cycles
   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end

   initial begin
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      check({30'h0, pslverr, pready}, 32'h0);
      check(prdata, 32'h0);
      presetn <= 1'b1;
      t_table();
      t_write();
      t_decode();
      t_reset();
      give_verdict();
   end
endmodule
